// [pkg/gis_pkg.sv]
// shared constants and carrier types for the pin interrupt and strap status block
package gis_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PIN_N = 32;
  localparam int HALF_N = 16;
  localparam logic [2:0] OWN_PORT = 3'h0;
  // register offsets
  localparam logic [11:0] OFS_IN_LO = 12'h328;
  localparam logic [11:0] OFS_IN_HI = 12'h32C;
  localparam logic [11:0] OFS_OUT_LO = 12'h330;
  localparam logic [11:0] OFS_OUT_HI = 12'h334;
  localparam logic [11:0] OFS_POLARITY = 12'h338;
  localparam logic [11:0] OFS_STATUS = 12'h33C;
  localparam logic [11:0] OFS_MASK = 12'h340;
  localparam logic [11:0] OFS_OPMODE = 12'h348;
  // reset values
  localparam logic [15:0] RST_OUT = 16'h0000;
  localparam logic [31:0] RST_POLARITY = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS = 32'h8000_0000;
  localparam logic [31:0] RST_MASK = 32'h0000_0000;
  localparam logic [2:0] RST_PORTCFG = 3'h0;
  localparam logic [1:0] RST_CHIPMODE = 2'h0;
  localparam logic RST_HOTPLUG = 1'b1;
  localparam logic RST_CLOCK_BUFFER_POWERED_DOWN = 1'b1;
  localparam logic RST_LPS = 1'b0;
  localparam logic [2:0] RST_I2C = 3'h0;
  // operation-mode field positions
  localparam int OPM_PORTCFG_LSB = 6;
  localparam int OPM_CHIPMODE_LSB = 9;
  localparam int OPM_CKMODE = 13;
  localparam int OPM_DMA = 14;
  localparam int OPM_CDEP = 21;
  localparam int OPM_SCAN = 22;
  localparam int OPM_HOTPLUG = 23;
  localparam int OPM_SURPRISE = 24;
  localparam int OPM_WIDE = 25;
  localparam int OPM_CLKBUF = 26;
  localparam int OPM_LPS = 27;
  localparam int OPM_I2C_LSB = 28;
  // clock-request pins
  localparam logic [15:0] CLKREQ_PINS = 16'hFF00;

  typedef struct packed {
    logic [2:0] portcfg;
    logic [1:0] chipmode;
    logic ckmode;
    logic dma_on;
    logic cross_domain_endpoint_on;
    logic scan_test_flag;
    logic hotplug_pins;
    logic surprise_removal_support;
    logic wide_expander_select;
    logic clock_buffer_powered_down;
    logic low_power_substate_pins;
    logic [2:0] i2c_addr;
  } gis_strap_s;

  typedef struct packed {
    logic wr;
    logic [2:0] port;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } gis_cfg_req_s;
endpackage

// [design/gis_pin_half.sv]
// one half of the pin bank: output drive and input read-back
`timescale 1ns/1ps
module gis_pin_half #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // register side
  input wire logic [W-1:0] out_data,
  input wire logic [2*W-1:0] dir,
  input wire logic [W-1:0] pin_off,
  output logic [W-1:0] in_read_ff,
  // pins
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_out_ff,
  output logic [W-1:0] pin_oe_n_ff
);
  logic [W-1:0] is_out;
  logic [W-1:0] drive;

  // direction bit of pin n sits at odd position 2n+1
  for (genvar n = 0; n < W; n++) begin : g_dir
    assign is_out[n] = dir[2*n+1];
  end
  assign drive = is_out & ~pin_off;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_ff <= '0;
      pin_oe_n_ff <= '1;
    end else if (clk_en) begin
      pin_out_ff <= out_data & drive; // R1 R2
      pin_oe_n_ff <= ~drive; // R1 R2
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_read_ff <= '0;
    end else if (clk_en) begin
      in_read_ff <= pin_in & ~is_out; // R18
    end
  end

  chk_input_reads_zero: assert property (@(posedge core_clk) disable iff (!rst_n) // R18
    $past(clk_en) && $past(is_out[0]) |-> !in_read_ff[0])
    else $error("input read of an output pin not zero");
endmodule

// [design/gis_strap_latch.sv]
// strap sampling held from the first enabled edge after reset
`timescale 1ns/1ps
module gis_strap_latch (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // straps
  input wire gis_pkg::gis_strap_s strap_in,
  // latched view
  output gis_pkg::gis_strap_s strap_ff,
  output logic latched_ff
);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_ff <= 1'b0;
    end else if (clk_en) begin
      latched_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_ff <= '0;
      strap_ff.portcfg <= gis_pkg::RST_PORTCFG;
      strap_ff.chipmode <= gis_pkg::RST_CHIPMODE;
      strap_ff.hotplug_pins <= gis_pkg::RST_HOTPLUG; // R11
      strap_ff.clock_buffer_powered_down <= gis_pkg::RST_CLOCK_BUFFER_POWERED_DOWN; // R14
      strap_ff.low_power_substate_pins <= gis_pkg::RST_LPS;
      strap_ff.i2c_addr <= gis_pkg::RST_I2C;
    end else if (clk_en && !latched_ff) begin
      strap_ff <= strap_in; // R20
    end
  end

  chk_strap_held_stable: assert property (@(posedge core_clk) disable iff (!rst_n) // R20
    latched_ff && $past(latched_ff) |-> strap_ff == $past(strap_ff))
    else $error("strap view changed after capture");
endmodule

// [design/gis_top.sv]
// pin output, pin interrupt and strap status registers of the first port
`timescale 1ns/1ps
// Overview of operation
// R1 - low output bit n drives pin n when direction bit 2n+1 of low direction set.
// R2 - high output bit n-16 drives pin n when its odd high direction bit set.
// R3 - polarity bit set means active-high interrupt input, clear active-low; reset clear.
// R4 - read-only status shows one active bit per pin; resets to top bit only.
// R5 - mask bit set masks that pin's interrupt; reset unmasked.
// R6 - operation-mode bits 8:6 show latched port-lane arrangement straps.
// R7 - operation-mode bits 10:9 show the two chip-mode straps, read-only.
// R8 - operation-mode bit 13 shows reference-clock mode strap.
// R9 - bit 14 shows DMA enabled, bit 21 cross-domain end-point enabled.
// R10 - bit 22 reads one in scan test mode, else zero.
// R11 - bit 23 shows hot-plug strap; when one all pins are hot-plug, default one.
// R12 - bit 24 shows surprise hot-plug support enabled.
// R13 - bit 25 shows expander width: zero 16-bit, one 40-bit.
// R14 - bit 26 shows clock-buffer power-down strap; default one.
// R15 - bit 27 shows substate strap; when one pins 8-15 become clock requests.
// R16 - bits 30:28 show the three latched target address straps.
// R17 - these registers exist only in the first port's configuration space.
// R18 - input read returns zero for output pins, sampled level for input pins.
// R19 - status active at polarity-chosen level; combined interrupt only for unmasked actives.
// R20 - reserved output halves read zero, ignore writes; straps latched once at reset.
module gis_top (
  // clock, enable and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // configuration access
  input wire logic cfg_req,
  input wire gis_pkg::gis_cfg_req_s cfg_cmd,
  output logic cfg_ack_ff,
  output logic [31:0] cfg_rdata_ff,
  // direction registers held elsewhere
  input wire logic [31:0] dir_low,
  input wire logic [31:0] dir_high,
  // straps
  input wire logic [2:0] portcfg_strap,
  input wire logic [1:0] chipmode_strap,
  input wire logic ckmode_strap,
  input wire logic dma_on,
  input wire logic cross_domain_endpoint_on,
  input wire logic scan_test_flag,
  input wire logic hot_plug_strap_n,
  input wire logic surprise_removal_support,
  input wire logic wide_expander_select,
  input wire logic clock_buffer_down_strap_n,
  input wire logic low_power_substate_strap_n,
  input wire logic [2:0] i2c_addr_strap,
  // pins
  input wire logic [31:0] gpio_in,
  output logic [31:0] gpio_out_ff,
  output logic [31:0] gpio_oe_n_ff,
  // mode and interrupt outputs
  output logic hotplug_mode_ff,
  output logic clkreq_mode_ff,
  output logic irq_ff
);
  logic [15:0] out_lo_ff;
  logic [15:0] out_hi_ff;
  logic [31:0] pol_ff;
  logic [31:0] mask_ff;
  logic [31:0] status_ff;
  logic [15:0] in_lo;
  logic [15:0] in_hi;
  logic [15:0] off_lo;
  logic [15:0] off_hi;
  logic [31:0] opmode;
  logic [31:0] nxt_rdata;
  logic take;
  logic own_port;
  logic wr_hit;
  logic [31:0] out_lo_merge;
  logic [31:0] out_hi_merge;
  gis_pkg::gis_strap_s strap_raw;
  gis_pkg::gis_strap_s strap_q;
  logic strap_done;

  // byte-lane merge for writes
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // strap gathering and capture
  always_comb begin
    strap_raw = '0;
    strap_raw.portcfg = portcfg_strap;
    strap_raw.chipmode = chipmode_strap;
    strap_raw.ckmode = ckmode_strap;
    strap_raw.dma_on = dma_on;
    strap_raw.cross_domain_endpoint_on = cross_domain_endpoint_on;
    strap_raw.scan_test_flag = scan_test_flag;
    strap_raw.hotplug_pins = ~hot_plug_strap_n;
    strap_raw.surprise_removal_support = surprise_removal_support;
    strap_raw.wide_expander_select = wide_expander_select;
    strap_raw.clock_buffer_powered_down = ~clock_buffer_down_strap_n;
    strap_raw.low_power_substate_pins = ~low_power_substate_strap_n;
    strap_raw.i2c_addr = i2c_addr_strap;
  end

  gis_strap_latch u_strap (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .strap_in(strap_raw),
    .strap_ff(strap_q),
    .latched_ff(strap_done)
  );

  // pin takeover by hot-plug and clock-request modes
  assign off_lo = strap_q.hotplug_pins ? 16'hFFFF : // R11
                  (strap_q.low_power_substate_pins ? gis_pkg::CLKREQ_PINS : 16'h0000); // R15
  assign off_hi = strap_q.hotplug_pins ? 16'hFFFF : 16'h0000; // R11

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hotplug_mode_ff <= gis_pkg::RST_HOTPLUG;
      clkreq_mode_ff <= gis_pkg::RST_LPS;
    end else if (clk_en) begin
      hotplug_mode_ff <= strap_q.hotplug_pins; // R11
      clkreq_mode_ff <= strap_q.low_power_substate_pins; // R15
    end
  end

  gis_pin_half #(.W(gis_pkg::HALF_N)) u_lo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .out_data(out_lo_ff),
    .dir(dir_low),
    .pin_off(off_lo),
    .in_read_ff(in_lo),
    .pin_in(gpio_in[15:0]),
    .pin_out_ff(gpio_out_ff[15:0]),
    .pin_oe_n_ff(gpio_oe_n_ff[15:0])
  );

  gis_pin_half #(.W(gis_pkg::HALF_N)) u_hi (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .out_data(out_hi_ff),
    .dir(dir_high),
    .pin_off(off_hi),
    .in_read_ff(in_hi),
    .pin_in(gpio_in[31:16]),
    .pin_out_ff(gpio_out_ff[31:16]),
    .pin_oe_n_ff(gpio_oe_n_ff[31:16])
  );

  // access decode
  assign take = clk_en && cfg_req;
  assign own_port = cfg_cmd.port == gis_pkg::OWN_PORT; // R17
  assign wr_hit = take && cfg_cmd.wr && own_port;

  // byte-lane merge of output halves, upper half dropped at the register
  assign out_lo_merge = merge_be({16'h0000, out_lo_ff}, cfg_cmd.wdata, cfg_cmd.be);
  assign out_hi_merge = merge_be({16'h0000, out_hi_ff}, cfg_cmd.wdata, cfg_cmd.be);

  // writable registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_lo_ff <= gis_pkg::RST_OUT;
      out_hi_ff <= gis_pkg::RST_OUT;
    end else if (wr_hit) begin
      if (cfg_cmd.addr == gis_pkg::OFS_OUT_LO) begin
        out_lo_ff <= out_lo_merge[15:0]; // R1 R20
      end
      if (cfg_cmd.addr == gis_pkg::OFS_OUT_HI) begin
        out_hi_ff <= out_hi_merge[15:0]; // R2 R20
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pol_ff <= gis_pkg::RST_POLARITY;
    end else if (wr_hit && cfg_cmd.addr == gis_pkg::OFS_POLARITY) begin
      pol_ff <= merge_be(pol_ff, cfg_cmd.wdata, cfg_cmd.be); // R3
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= gis_pkg::RST_MASK;
    end else if (wr_hit && cfg_cmd.addr == gis_pkg::OFS_MASK) begin
      mask_ff <= merge_be(mask_ff, cfg_cmd.wdata, cfg_cmd.be); // R5
    end
  end

  // interrupt status and combined interrupt
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= gis_pkg::RST_STATUS; // R4
    end else if (clk_en) begin
      status_ff <= ~(gpio_in ^ pol_ff); // R3 R19
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else if (clk_en) begin
      irq_ff <= |(status_ff & ~mask_ff); // R5 R19
    end
  end

  // operation-mode view
  always_comb begin
    opmode = '0;
    opmode[gis_pkg::OPM_PORTCFG_LSB +: 3] = strap_q.portcfg; // R6
    opmode[gis_pkg::OPM_CHIPMODE_LSB +: 2] = strap_q.chipmode; // R7
    opmode[gis_pkg::OPM_CKMODE] = strap_q.ckmode; // R8
    opmode[gis_pkg::OPM_DMA] = strap_q.dma_on; // R9
    opmode[gis_pkg::OPM_CDEP] = strap_q.cross_domain_endpoint_on; // R9
    opmode[gis_pkg::OPM_SCAN] = strap_q.scan_test_flag; // R10
    opmode[gis_pkg::OPM_HOTPLUG] = strap_q.hotplug_pins; // R11
    opmode[gis_pkg::OPM_SURPRISE] = strap_q.surprise_removal_support; // R12
    opmode[gis_pkg::OPM_WIDE] = strap_q.wide_expander_select; // R13
    opmode[gis_pkg::OPM_CLKBUF] = strap_q.clock_buffer_powered_down; // R14
    opmode[gis_pkg::OPM_LPS] = strap_q.low_power_substate_pins; // R15
    opmode[gis_pkg::OPM_I2C_LSB +: 3] = strap_q.i2c_addr; // R16
  end

  // read mux
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (own_port && !cfg_cmd.wr) begin // R17
      unique case (cfg_cmd.addr)
        gis_pkg::OFS_IN_LO: nxt_rdata = {16'h0000, in_lo}; // R18
        gis_pkg::OFS_IN_HI: nxt_rdata = {16'h0000, in_hi}; // R18
        gis_pkg::OFS_OUT_LO: nxt_rdata = {16'h0000, out_lo_ff}; // R20
        gis_pkg::OFS_OUT_HI: nxt_rdata = {16'h0000, out_hi_ff}; // R20
        gis_pkg::OFS_POLARITY: nxt_rdata = pol_ff;
        gis_pkg::OFS_STATUS: nxt_rdata = status_ff; // R4
        gis_pkg::OFS_MASK: nxt_rdata = mask_ff;
        gis_pkg::OFS_OPMODE: nxt_rdata = opmode;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ack_ff <= 1'b0;
      cfg_rdata_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      cfg_ack_ff <= cfg_req;
      cfg_rdata_ff <= cfg_req ? nxt_rdata : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_rd(logic [11:0] ofs);
    take && !cfg_cmd.wr && own_port && cfg_cmd.addr == ofs;
  endsequence

  sequence s_wr(logic [11:0] ofs);
    wr_hit && cfg_cmd.addr == ofs && cfg_cmd.be == 4'hF;
  endsequence

  chk_low_pin_drive: assert property ( // R1
    $past(clk_en) && $past(dir_low[1]) && !$past(off_lo[0])
    |-> !gpio_oe_n_ff[0] && gpio_out_ff[0] == $past(out_lo_ff[0]))
    else $error("low pin not driven from output register");
  chk_high_pin_drive: assert property ( // R2
    $past(clk_en) && $past(dir_high[1]) && !$past(off_hi[0])
    |-> !gpio_oe_n_ff[16] && gpio_out_ff[16] == $past(out_hi_ff[0]))
    else $error("high pin not driven from output register");
  chk_status_polarity: assert property ( // R3 R19
    clk_en |=> status_ff == ~($past(gpio_in) ^ $past(pol_ff)))
    else $error("status does not follow polarity");
  chk_status_read: assert property ( // R4
    s_rd(gis_pkg::OFS_STATUS) |=> cfg_ack_ff && cfg_rdata_ff == $past(status_ff))
    else $error("status read wrong");
  chk_mask_gates_irq: assert property ( // R5 R19
    clk_en |=> irq_ff == |($past(status_ff) & ~$past(mask_ff)))
    else $error("combined interrupt not gated by mask");
  chk_opmode_fields: assert property ( // R6 R7 R8 R9 R10 R11 R12 R13 R14 R15 R16
    s_rd(gis_pkg::OFS_OPMODE) |=> cfg_rdata_ff[8:6] == $past(strap_q.portcfg)
    && cfg_rdata_ff[10:9] == $past(strap_q.chipmode)
    && cfg_rdata_ff[30:28] == $past(strap_q.i2c_addr)
    && cfg_rdata_ff[27:26] == $past({strap_q.low_power_substate_pins,
       strap_q.clock_buffer_powered_down})
    && cfg_rdata_ff[25:21] == $past({strap_q.wide_expander_select,
       strap_q.surprise_removal_support, strap_q.hotplug_pins,
       strap_q.scan_test_flag, strap_q.cross_domain_endpoint_on})
    && cfg_rdata_ff[14:13] == $past({strap_q.dma_on, strap_q.ckmode}))
    else $error("operation mode read wrong");
  chk_hotplug_release: assert property ( // R11
    $past(clk_en) && $past(strap_q.hotplug_pins) |-> &gpio_oe_n_ff)
    else $error("pin driven in hot-plug mode");
  chk_clkreq_release: assert property ( // R15
    $past(clk_en) && $past(strap_q.low_power_substate_pins) |-> &gpio_oe_n_ff[15:8])
    else $error("clock request pin driven");
  chk_other_port: assert property ( // R17
    take && !own_port |=> cfg_ack_ff && cfg_rdata_ff == 32'h0000_0000)
    else $error("other port saw registers");
  chk_reserved_zero: assert property ( // R20
    s_rd(gis_pkg::OFS_OUT_HI) |=> cfg_rdata_ff[31:16] == 16'h0000)
    else $error("reserved half not zero");
  chk_reserved_lo_zero: assert property ( // R20
    s_rd(gis_pkg::OFS_OUT_LO) |=> cfg_rdata_ff[31:16] == 16'h0000)
    else $error("reserved low half not zero");
  chk_low_out_write: assert property ( // R1 R20
    s_wr(gis_pkg::OFS_OUT_LO) |=> out_lo_ff == $past(cfg_cmd.wdata[15:0]))
    else $error("low output write lost");
  chk_polarity_write: assert property ( // R3
    s_wr(gis_pkg::OFS_POLARITY) |=> pol_ff == $past(cfg_cmd.wdata))
    else $error("polarity write lost");
  chk_mask_write: assert property ( // R5
    s_wr(gis_pkg::OFS_MASK) |=> mask_ff == $past(cfg_cmd.wdata))
    else $error("mask write lost");
  chk_other_port_write: assert property ( // R17
    take && cfg_cmd.wr && !own_port |=> $stable(out_lo_ff) && $stable(out_hi_ff)
    && $stable(pol_ff) && $stable(mask_ff))
    else $error("other port write landed");
  chk_freeze_holds: assert property ( // R19
    !clk_en |=> $stable(status_ff) && $stable(irq_ff) && $stable(cfg_ack_ff))
    else $error("state moved while enable low");
endmodule

// [bench/gis_board_model.sv]
// board-side model of the signals wired to the general-purpose pins
`timescale 1ns/1ps
module gis_board_model (
  // device pins
  input wire logic [31:0] gpio_out,
  input wire logic [31:0] gpio_oe_n,
  // levels the board applies to undriven pins
  input wire logic [31:0] board_level,
  // resolved pin levels
  output logic [31:0] pin_level
);
  // driven pins follow the device, others the board
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      pin_level[i] = gpio_oe_n[i] ? board_level[i] : gpio_out[i];
    end
  end
endmodule

// [bench/tb.sv]
// self-checking bench for the pin interrupt and strap status block
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("mismatch %s expected %h seen %h", what, (exp), (got)); \
    end \
  end
module tb;
  int fail_count = 0;
  int check_count = 0;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic cfg_req = 1'b0;
  gis_pkg::gis_cfg_req_s cfg_cmd = '0;
  logic cfg_ack_ff;
  logic [31:0] cfg_rdata_ff;
  logic [31:0] dir_low = 32'h0000_0000;
  logic [31:0] dir_high = 32'h0000_0000;
  gis_pkg::gis_strap_s st = '0;
  logic [31:0] board_level = 32'h7FFF_FFFF;
  logic [31:0] gpio_in;
  logic [31:0] gpio_out_ff;
  logic [31:0] gpio_oe_n_ff;
  logic hotplug_mode_ff;
  logic clkreq_mode_ff;
  logic irq_ff;

  always #2 core_clk = ~core_clk;

  gis_top DUT (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .cfg_req(cfg_req),
    .cfg_cmd(cfg_cmd),
    .cfg_ack_ff(cfg_ack_ff),
    .cfg_rdata_ff(cfg_rdata_ff),
    .dir_low(dir_low),
    .dir_high(dir_high),
    .portcfg_strap(st.portcfg),
    .chipmode_strap(st.chipmode),
    .ckmode_strap(st.ckmode),
    .dma_on(st.dma_on),
    .cross_domain_endpoint_on(st.cross_domain_endpoint_on),
    .scan_test_flag(st.scan_test_flag),
    .hot_plug_strap_n(~st.hotplug_pins),
    .surprise_removal_support(st.surprise_removal_support),
    .wide_expander_select(st.wide_expander_select),
    .clock_buffer_down_strap_n(~st.clock_buffer_powered_down),
    .low_power_substate_strap_n(~st.low_power_substate_pins),
    .i2c_addr_strap(st.i2c_addr),
    .gpio_in(gpio_in),
    .gpio_out_ff(gpio_out_ff),
    .gpio_oe_n_ff(gpio_oe_n_ff),
    .hotplug_mode_ff(hotplug_mode_ff),
    .clkreq_mode_ff(clkreq_mode_ff),
    .irq_ff(irq_ff)
  );

  gis_board_model board (
    .gpio_out(gpio_out_ff),
    .gpio_oe_n(gpio_oe_n_ff),
    .board_level(board_level),
    .pin_level(gpio_in)
  );

  // direction word with odd bit 2n+1 set for each pin n whose bit n is set in h
  function automatic logic [31:0] spread(input logic [15:0] h);
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int i = 0; i < 16; i++) begin
      v[2*i+1] = h[i];
    end
    return v;
  endfunction

  // expected operation-mode word from strap levels
  function automatic logic [31:0] opm(input gis_pkg::gis_strap_s s);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[8:6] = s.portcfg;
    v[10:9] = s.chipmode;
    v[13] = s.ckmode;
    v[14] = s.dma_on;
    v[21] = s.cross_domain_endpoint_on;
    v[22] = s.scan_test_flag;
    v[23] = s.hotplug_pins;
    v[24] = s.surprise_removal_support;
    v[25] = s.wide_expander_select;
    v[26] = s.clock_buffer_powered_down;
    v[27] = s.low_power_substate_pins;
    v[30:28] = s.i2c_addr;
    return v;
  endfunction

  task automatic do_reset();
    @(posedge core_clk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic cfg_acc(input logic w, input logic [2:0] port, input logic [11:0] addr,
                         input logic [31:0] wd, input logic [3:0] be, output logic [31:0] rd);
    @(posedge core_clk);
    #1;
    cfg_req = 1'b1;
    cfg_cmd.wr = w;
    cfg_cmd.port = port;
    cfg_cmd.addr = addr;
    cfg_cmd.wdata = wd;
    cfg_cmd.be = be;
    @(posedge core_clk);
    #1;
    cfg_req = 1'b0;
    `CHK("ack", 1'b1, cfg_ack_ff)
    rd = cfg_rdata_ff;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] rd;
    cfg_acc(1'b1, 3'h0, addr, wd, be, rd);
  endtask

  task automatic rchk(input string name, input logic [2:0] port, input logic [11:0] addr,
                      input logic [31:0] exp);
    logic [31:0] rd;
    cfg_acc(1'b0, port, addr, 32'h0000_0000, 4'h0, rd);
    `CHK(name, exp, rd)
  endtask

  task automatic t_after_reset();
    do_reset();
    `CHK("oe_n", 32'hFFFF_FFFF, gpio_oe_n_ff)
    `CHK("gpio_out", 32'h0000_0000, gpio_out_ff)
    rchk("polarity", 3'h0, 12'h338, 32'h0000_0000);
    rchk("mask", 3'h0, 12'h340, 32'h0000_0000);
    rchk("out_lo", 3'h0, 12'h330, 32'h0000_0000);
    rchk("out_hi", 3'h0, 12'h334, 32'h0000_0000);
    rchk("status", 3'h0, 12'h33C, 32'h8000_0000);
    rchk("opmode", 3'h0, 12'h348, opm(st));
    rchk("unmapped", 3'h0, 12'h344, 32'h0000_0000);
    rchk("other_port", 3'h1, 12'h348, 32'h0000_0000);
  endtask

  task automatic t_outputs();
    logic [31:0] rd;
    dir_low = spread(16'h00FF);
    dir_high = spread(16'hF000);
    wr(12'h330, 32'hFFFF_A5A5, 4'hF);
    wr(12'h334, 32'h0000_5A5A, 4'h2);
    cfg_acc(1'b1, 3'h2, 12'h330, 32'h0000_0000, 4'hF, rd);
    rchk("out_lo", 3'h0, 12'h330, 32'h0000_A5A5);
    rchk("out_hi", 3'h0, 12'h334, 32'h0000_5A00);
    `CHK("gpio_out", 32'h5000_00A5, gpio_out_ff)
    `CHK("oe_n", 32'h0FFF_FF00, gpio_oe_n_ff)
    rchk("in_lo", 3'h0, 12'h328, 32'h0000_FF00);
    rchk("in_hi", 3'h0, 12'h32C, 32'h0000_0FFF);
    rchk("status", 3'h0, 12'h33C, 32'hA000_005A);
  endtask

  task automatic t_irq();
    dir_low = 32'h0000_0000;
    dir_high = 32'h0000_0000;
    board_level = 32'h0000_0001;
    wr(12'h338, 32'hFFFF_0000, 4'hF);
    wr(12'h340, 32'hFFFF_FFFF, 4'hF);
    rchk("status", 3'h0, 12'h33C, 32'h0000_FFFE);
    rchk("mask", 3'h0, 12'h340, 32'hFFFF_FFFF);
    `CHK("irq masked", 1'b0, irq_ff)
    wr(12'h340, 32'h0000_00FD, 4'h1);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("irq unmasked", 1'b1, irq_ff)
    board_level = 32'h0000_0003;
    @(posedge core_clk);
    #1;
    `CHK("irq held", 1'b1, irq_ff)
    @(posedge core_clk);
    #1;
    `CHK("irq gone", 1'b0, irq_ff)
  endtask

  task automatic t_freeze();
    @(posedge core_clk);
    #1;
    clk_en = 1'b0;
    cfg_req = 1'b1;
    cfg_cmd.wr = 1'b0;
    cfg_cmd.port = 3'h0;
    cfg_cmd.addr = 12'h338;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("ack frozen", 1'b0, cfg_ack_ff)
    cfg_req = 1'b0;
    clk_en = 1'b1;
  endtask

  task automatic t_straps();
    gis_pkg::gis_strap_s old;
    logic [2:0] kk;
    logic [31:0] exp_oe;
    old = st;
    st = 17'h1_5A5A;
    repeat (2) @(posedge core_clk);
    rchk("opmode held", 3'h0, 12'h348, opm(old));
    dir_low = spread(16'hFFFF);
    dir_high = spread(16'hFFFF);
    for (int k = 0; k < 8; k++) begin
      kk = k[2:0];
      st = {kk, kk[1:0], kk[0], kk[1], kk[2], kk[1] ^ kk[0], (kk == 3'h3) || (kk == 3'h6),
            kk[2] ^ kk[0], kk[0], kk[1], (kk == 3'h5) || (kk == 3'h6), ~kk};
      do_reset();
      rchk("opmode", 3'h0, 12'h348, opm(st));
      exp_oe = st.hotplug_pins ? 32'hFFFF_FFFF :
               (st.low_power_substate_pins ? 32'h0000_FF00 : 32'h0000_0000);
      `CHK("hotplug_mode", st.hotplug_pins, hotplug_mode_ff)
      `CHK("clkreq_mode", st.low_power_substate_pins, clkreq_mode_ff)
      `CHK("oe_n mode", exp_oe, gpio_oe_n_ff)
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    t_after_reset();
    t_outputs();
    t_irq();
    t_freeze();
    t_straps();
    final_report();
  end

  initial begin
    #40000;
    fail_count++;
    final_report();
  end
endmodule
